// [rtl/sdram_ctrl_map.vh]
`ifndef SDRAM_CTRL_MAP_VH
`define SDRAM_CTRL_MAP_VH
// *****************************************
// register offsets of the command port
// *****************************************
`define OFS_CMD 3'h0
`define OFS_WDATA 3'h1
`define OFS_CFG 3'h2
`define OFS_STATUS 3'h3
`define OFS_RDATA 3'h4
// *****************************************
// field positions
// *****************************************
`define CMD_OP_LSB 0
`define CMD_BANK_LSB 4
`define CMD_AP_BIT 6
`define CMD_ADDR_LSB 16
`define WD_MASK_LSB 16
`define CFG_CL_BIT 2
`define CFG_RESET 8'h03
`define SD_AUTO_PRECHARGE_SELECT 10
// *****************************************
// timing
// *****************************************
`define CLK_MHZ 25
`define NS2CYC(t) ((((t)*`CLK_MHZ)+999)/1000)
`define PRECHARGE_PERIOD_NS 19
`define ROW_CYCLE_TIME_NS 70
`define RCD_NS 19
`define WR_NS 14
`define REF_PERIOD_MS 64
`define PD_LIMIT_CYC (`REF_PERIOD_MS*`CLK_MHZ*1000)
`endif

// [rtl/sdram_command_engine.v]
// Strobed register access and the address map were chosen for this implementation.
`include "sdram_ctrl_map.vh"

module sdram_command_engine #(
   parameter PD_LIMIT = `PD_LIMIT_CYC
) (
   input wire ref_clk,
   input wire resetn,
   input wire [2:0] bus_addr,
   input wire [31:0] bus_wdata,
   input wire bus_wr,
   input wire bus_rd,
   output reg [31:0] bus_rdata,
   output reg sd_cke,
   output reg sd_cs_n,
   output reg sd_ras_n,
   output reg sd_cas_n,
   output reg sd_we_n,
   output reg bank_select_lo,
   output reg bank_select_hi,
   output reg [12:0] sd_addr,
   output reg [1:0] sd_dqm,
   input wire [15:0] sd_dq_in,
   output reg [15:0] sd_dq_out,
   output reg sd_dq_oe
);

// *****************************************
// constants
// *****************************************
localparam [3:0] OP_NOP = 4'h0;
localparam [3:0] OP_ACT = 4'h1;
localparam [3:0] OP_WRITE = 4'h2;
localparam [3:0] OP_READ = 4'h3;
localparam [3:0] OP_PRE = 4'h4;
localparam [3:0] OP_BST = 4'h5;
localparam [3:0] OP_AREF = 4'h6;
localparam [3:0] OP_SREF_IN = 4'h7;
localparam [3:0] OP_SREF_OUT = 4'h8;
localparam [3:0] OP_PD_IN = 4'h9;
localparam [3:0] OP_PD_OUT = 4'ha;
localparam [3:0] OP_DPD_IN = 4'hb;
localparam [3:0] OP_DPD_OUT = 4'hc;
localparam [3:0] OP_SUSP = 4'hd;
localparam [3:0] OP_RESUME = 4'he;

localparam [2:0] ST_IDLE = 3'd0;
localparam [2:0] ST_WAIT = 3'd1;
localparam [2:0] ST_WBURST = 3'd2;
localparam [2:0] ST_RBURST = 3'd3;
localparam [2:0] ST_SREF = 3'd4;
localparam [2:0] ST_PDN = 3'd5;
localparam [2:0] ST_DPD = 3'd6;

localparam integer RP_CYC = `NS2CYC(`PRECHARGE_PERIOD_NS);
localparam integer RC_CYC = `NS2CYC(`ROW_CYCLE_TIME_NS);
localparam integer RCD_CYC = `NS2CYC(`RCD_NS);
localparam integer WR_CYC = `NS2CYC(`WR_NS);
localparam integer PD_CYC = PD_LIMIT;
localparam [7:0] T_RP = RP_CYC[7:0];
localparam [7:0] T_RC = RC_CYC[7:0];
localparam [7:0] T_RCD = RCD_CYC[7:0];
localparam [7:0] T_WR = WR_CYC[7:0];
localparam [20:0] PD_MAX = PD_CYC[20:0];

function [3:0] burst_len;
   input [1:0] code;
   begin
      burst_len = 4'h1 << code;
   end
endfunction

// *****************************************
// state
// *****************************************
reg [2:0] state;
reg [7:0] timer;
reg [3:0] open_bank;
reg [3:0] bcnt;
reg ap_pend;
reg [1:0] cur_bank;
reg [7:0] cfg;
reg refused;
reg init_needed;
reg aref_due;
reg suspended;
reg cke_d;
reg [3:0] wptr;
reg [17:0] wbuf [0:7];
reg [3:0] rd_pipe;
reg [15:0] rdata;
reg [20:0] pd_cnt;

wire take = bus_wr && (bus_addr == `OFS_CMD);
wire [3:0] op = bus_wdata[`CMD_OP_LSB+3:`CMD_OP_LSB];
wire [1:0] bank = bus_wdata[`CMD_BANK_LSB+1:`CMD_BANK_LSB];
wire ap = bus_wdata[`CMD_AP_BIT];
wire [12:0] cmd_addr = bus_wdata[`CMD_ADDR_LSB+12:`CMD_ADDR_LSB];
wire [3:0] blen = burst_len(cfg[1:0]);
wire cl3 = cfg[`CFG_CL_BIT];
wire bank_open = open_bank[bank];
wire in_burst = (state == ST_WBURST) || (state == ST_RBURST);
wire advance = cke_d;

reg accept;
always @* begin
   accept = 1'b0;
   case (state)
      ST_IDLE: begin
         case (op)
            OP_ACT: accept = !bank_open && !init_needed;
            OP_WRITE: accept = bank_open && (wptr != 4'h0) && (rd_pipe == 4'h0);
            OP_READ: accept = bank_open;
            OP_PRE: accept = 1'b1;
            OP_AREF: accept = (open_bank == 4'h0);
            OP_SREF_IN: accept = (open_bank == 4'h0);
            OP_PD_IN: accept = (open_bank == 4'h0);
            OP_DPD_IN: accept = (open_bank == 4'h0);
            default: accept = 1'b0;
         endcase
      end
      ST_WBURST, ST_RBURST: begin
         accept = (op == OP_BST) || (op == OP_RESUME) ||
                  (op == OP_SUSP) || (op == OP_PD_IN);
      end
      ST_SREF: accept = (op == OP_SREF_OUT);
      ST_PDN: accept = (op == OP_PD_OUT);
      ST_DPD: accept = (op == OP_DPD_OUT);
      default: accept = 1'b0;
   endcase
end

// *****************************************
// command sequencer
// *****************************************
always @(posedge ref_clk or negedge resetn) begin
   if (!resetn) begin
      state <= ST_IDLE;
      timer <= 8'h00;
      open_bank <= 4'h0;
      bcnt <= 4'h0;
      ap_pend <= 1'b0;
      cur_bank <= 2'b00;
      aref_due <= 1'b0;
      suspended <= 1'b0;
      init_needed <= 1'b0;
      pd_cnt <= 21'h000000;
      sd_cke <= 1'b1;
      sd_cs_n <= 1'b1;
      sd_ras_n <= 1'b1;
      sd_cas_n <= 1'b1;
      sd_we_n <= 1'b1;
      bank_select_lo <= 1'b0;
      bank_select_hi <= 1'b0;
      sd_addr <= 13'h0000;
      sd_dqm <= 2'b00;
      sd_dq_out <= 16'h0000;
      sd_dq_oe <= 1'b0;
   end else begin
      // default command each cycle is a plain nop
      sd_cs_n <= 1'b0;
      sd_ras_n <= 1'b1;
      sd_cas_n <= 1'b1;
      sd_we_n <= 1'b1;
      if (bus_wr && (bus_addr == `OFS_CFG))
         init_needed <= 1'b0;
      case (state)
         ST_IDLE: begin
            if (take && accept) begin
               bank_select_lo <= bank[0];
               bank_select_hi <= bank[1];
               sd_addr <= cmd_addr;
               cur_bank <= bank;
               case (op)
                  OP_ACT: begin
                     sd_ras_n <= 1'b0;
                     open_bank[bank] <= 1'b1;
                     timer <= T_RCD;
                     state <= ST_WAIT;
                  end
                  OP_WRITE: begin
                     sd_cas_n <= 1'b0;
                     sd_we_n <= 1'b0;
                     sd_addr <= {2'b00, ap, cmd_addr[9:0]};
                     ap_pend <= ap;
                     sd_dq_out <= wbuf[0][15:0];
                     sd_dqm <= wbuf[0][17:16];
                     sd_dq_oe <= 1'b1;
                     bcnt <= 4'h1;
                     state <= ST_WBURST;
                  end
                  OP_READ: begin
                     sd_cas_n <= 1'b0;
                     sd_addr <= {2'b00, ap, cmd_addr[9:0]};
                     ap_pend <= ap;
                     sd_dqm <= 2'b00;
                     bcnt <= 4'h1;
                     state <= ST_RBURST;
                  end
                  OP_PRE: begin
                     sd_ras_n <= 1'b0;
                     sd_we_n <= 1'b0;
                     sd_addr[`SD_AUTO_PRECHARGE_SELECT] <= ap;
                     if (ap)
                        open_bank <= 4'h0;
                     else
                        open_bank[bank] <= 1'b0;
                     timer <= T_RP;
                     state <= ST_WAIT;
                  end
                  OP_AREF: begin
                     sd_ras_n <= 1'b0;
                     sd_cas_n <= 1'b0;
                     timer <= T_RC;
                     state <= ST_WAIT;
                  end
                  OP_SREF_IN: begin
                     sd_ras_n <= 1'b0;
                     sd_cas_n <= 1'b0;
                     sd_cke <= 1'b0;
                     state <= ST_SREF;
                  end
                  OP_PD_IN: begin
                     sd_cs_n <= 1'b1;
                     sd_cke <= 1'b0;
                     pd_cnt <= 21'h000000;
                     state <= ST_PDN;
                  end
                  default: begin
                     sd_we_n <= 1'b0;
                     sd_cke <= 1'b0;
                     state <= ST_DPD;
                  end
               endcase
            end
         end
         ST_WAIT: begin
            if (timer > 8'h01) begin
               timer <= timer - 8'h01;
            end else if (aref_due) begin
               // extra refresh after self refresh exit
               aref_due <= 1'b0;
               sd_ras_n <= 1'b0;
               sd_cas_n <= 1'b0;
               timer <= T_RC;
            end else begin
               state <= ST_IDLE;
            end
         end
         ST_WBURST, ST_RBURST: begin
            if (take && accept && (op == OP_BST)) begin
               sd_we_n <= 1'b0;
               sd_dq_oe <= 1'b0;
               sd_dqm <= 2'b00;
               sd_cke <= 1'b1;
               suspended <= 1'b0;
               timer <= T_WR;
               state <= (state == ST_WBURST) ? ST_WAIT : ST_IDLE;
            end else begin
               if (take && accept && (op == OP_RESUME))
                  sd_cke <= 1'b1;
               else if (take && accept)
                  sd_cke <= 1'b0;
               suspended <= !sd_cke || (take && accept && (op != OP_RESUME));
               // word moves only on edges the device really clocks
               if (advance) begin
                  if (bcnt == blen) begin
                     sd_dq_oe <= 1'b0;
                     sd_dqm <= 2'b00;
                     if (state == ST_WBURST) begin
                        if (ap_pend) begin
                           open_bank[cur_bank] <= 1'b0;
                           timer <= T_WR + T_RP;
                        end else begin
                           timer <= T_WR;
                        end
                        state <= ST_WAIT;
                     end else if (ap_pend) begin
                        open_bank[cur_bank] <= 1'b0;
                        timer <= T_RP;
                        state <= ST_WAIT;
                     end else begin
                        state <= ST_IDLE;
                     end
                  end else begin
                     bcnt <= bcnt + 4'h1;
                     if (state == ST_WBURST) begin
                        sd_dq_out <= wbuf[bcnt[2:0]][15:0];
                        sd_dqm <= wbuf[bcnt[2:0]][17:16];
                     end
                  end
               end
            end
         end
         ST_SREF: begin
            sd_cs_n <= 1'b1;
            if (take && accept) begin
               sd_cke <= 1'b1;
               aref_due <= 1'b1;
               timer <= T_RC;
               state <= ST_WAIT;
            end
         end
         ST_PDN: begin
            sd_cs_n <= 1'b1;
            pd_cnt <= pd_cnt + 21'h000001;
            // forced exit keeps the array inside its refresh period
            if ((take && accept) || (pd_cnt >= PD_MAX)) begin
               sd_cke <= 1'b1;
               timer <= 8'h01;
               state <= ST_WAIT;
            end
         end
         ST_DPD: begin
            sd_cs_n <= 1'b1;
            if (take && accept) begin
               sd_cke <= 1'b1;
               init_needed <= 1'b1;
               open_bank <= 4'h0;
               timer <= T_RC;
               state <= ST_WAIT;
            end
         end
         default: state <= ST_IDLE;
      endcase
   end
end

// *****************************************
// write buffer, read capture, flags
// *****************************************
always @(posedge ref_clk or negedge resetn) begin
   if (!resetn) begin
      wptr <= 4'h0;
      rd_pipe <= 4'h0;
      rdata <= 16'h0000;
      cke_d <= 1'b1;
      refused <= 1'b0;
      cfg <= `CFG_RESET;
   end else begin
      cke_d <= sd_cke;
      if (state == ST_WBURST && (op == OP_BST || bcnt == blen) &&
          ((take && accept && op == OP_BST) || advance))
         wptr <= 4'h0;
      else if (bus_wr && (bus_addr == `OFS_WDATA) && !wptr[3] && !in_burst)
         wptr <= wptr + 4'h1;
      rd_pipe <= {rd_pipe[2:0], (take && accept && state == ST_IDLE &&
                  op == OP_READ) || (state == ST_RBURST && advance &&
                  bcnt != blen && !(take && op == OP_BST))};
      // data arrive a cas latency after the edge that registers each read word,
      // which is one edge after we launch it
      if (cl3 ? rd_pipe[3] : rd_pipe[2])
         rdata <= sd_dq_in;
      if (bus_wr && (bus_addr == `OFS_CFG))
         cfg <= bus_wdata[7:0];
      // a fresh refusal wins over the clear
      if (take && !accept)
         refused <= 1'b1;
      else if (bus_wr && (bus_addr == `OFS_STATUS))
         refused <= 1'b0;
   end
end

always @(posedge ref_clk) begin
   if (bus_wr && (bus_addr == `OFS_WDATA) && !wptr[3] && !in_burst)
      wbuf[wptr[2:0]] <= {bus_wdata[`WD_MASK_LSB+1:`WD_MASK_LSB], bus_wdata[15:0]};
end

// *****************************************
// register read port
// *****************************************
always @(posedge ref_clk or negedge resetn) begin
   if (!resetn) begin
      bus_rdata <= 32'h00000000;
   end else if (bus_rd) begin
      case (bus_addr)
         `OFS_CFG: bus_rdata <= {24'h000000, cfg};
         `OFS_STATUS: bus_rdata <= {17'h00000, wptr, suspended, init_needed,
                                    refused, state, open_bank,
                                    (state != ST_IDLE)};
         `OFS_RDATA: bus_rdata <= {16'h0000, rdata};
         default: bus_rdata <= 32'h00000000;
      endcase
   end else begin
      bus_rdata <= 32'h00000000;
   end
end

endmodule // sdram_command_engine

// [rtl/dummy_never.v]
// kept empty: the whole engine lives in sdram_command_engine.v

// [bench/sdram_command_engine_properties.sv]
module sdram_command_engine_properties (
   input wire ref_clk,
   input wire resetn,
   input wire sd_cke,
   input wire sd_cs_n,
   input wire sd_ras_n,
   input wire sd_cas_n,
   input wire sd_we_n,
   input wire bank_select_lo,
   input wire bank_select_hi,
   input wire [12:0] sd_addr,
   input wire sd_dq_oe
);
   timeunit 1ns;
   timeprecision 1ps;
   wire [3:0] c = {sd_cs_n, sd_ras_n, sd_cas_n, sd_we_n};
   wire [1:0] bk = {bank_select_hi, bank_select_lo};
   wire any = !sd_cs_n && c[2:0] != 3'b111;
   wire pre = c == 4'b0010;
   wire aref = c == 4'b0001;
   logic [3:0] open_b;
   // ****************
   // bank bookkeeping
   // ****************
   // auto precharge counts as closed at once: writes and idle-only commands are judged by it
   always @(posedge ref_clk or negedge resetn) begin
      if (!resetn)
         open_b <= 4'h0;
      else if (c == 4'b0011)
         open_b[bk] <= 1'b1;
      else if (pre)
         open_b <= sd_addr[10] ? 4'h0 : open_b & ~(4'h1 << bk);
      else if (c[3:1] == 3'b010 && sd_addr[10])
         open_b[bk] <= 1'b0;
   end
   default clocking @(posedge ref_clk); endclocking
   default disable iff (!resetn);
   a_write_data: assert property (
      c == 4'b0100 |-> sd_dq_oe && sd_addr[12:11] == 2'b00) else $error("write without data");
   a_write_open: assert property (
      c == 4'b0100 |-> open_b[bk]) else $error("write to closed bank");
   a_precharge_gap: assert property (
      pre |=> !any) else $error("command in precharge period");
   a_recovery_gap: assert property (
      $fell(sd_dq_oe) |-> !pre) else $error("precharge in write recovery");
   a_refresh_gap: assert property (
      aref && sd_cke |=> !any [*2]) else $error("command in row cycle");
   a_refresh_idle: assert property (
      aref && sd_cke |-> open_b == 4'h0) else $error("refresh with open bank");
   a_sref_idle: assert property (
      aref && !sd_cke |-> open_b == 4'h0 ##1 sd_cs_n) else $error("bad self refresh entry");
   a_clock_quiet: assert property (
      !sd_cke && !$past(sd_cke) |-> !any) else $error("command while clock held");
endmodule // sdram_command_engine_properties
bind sdram_command_engine sdram_command_engine_properties u_sdram_command_engine_properties (.ref_clk, .resetn,
   .sd_cke, .sd_cs_n, .sd_ras_n, .sd_cas_n, .sd_we_n, .bank_select_lo, .bank_select_hi, .sd_addr, .sd_dq_oe);

// [bench/sdram_partner.sv]
module sdram_partner (
   input wire ref_clk,
   input wire sd_cke,
   input wire [3:0] cmd,
   input wire [1:0] bank,
   input wire [12:0] sd_addr,
   input wire [1:0] sd_dqm,
   input wire [15:0] sd_dq_out,
   input wire sd_dq_oe,
   input wire [2:0] cfg,
   output logic [15:0] sd_dq_in = 16'h5a5a
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [15:0] mem [0:4095];
   logic [15:0] p1, p2;
   logic [11:0] pos;
   logic [3:0] open_b = 4'h0;
   logic [3:0] left = 4'h0;
   logic cke_d = 1'b1, wr_on, ap, v1 = 1'b0, v2 = 1'b0, z1 = 1'b0;
   // clock held low one edge earlier freezes commands and burst steps (suspend, power down, self refresh); read data in flight still comes out
   wire run = cke_d && !cmd[3];
   wire wcmd = run && cmd[2:0] == 3'b100;
   wire rcmd = run && cmd[2:0] == 3'b101;
   wire stop = run && sd_cke && cmd[2:0] == 3'b110;
   wire pre = run && cmd[2:0] == 3'b010;
   // refresh ignores the address and leaves every bank closed; no partial array setting
   // can be programmed here, so self refresh keeps all banks
   wire refresh = run && cmd[2:0] == 3'b001;
   wire step = cke_d && left != 4'h0 && !(wcmd || rcmd || stop || pre);
   wire [11:0] a = (wcmd || rcmd) ? {bank, sd_addr[9:0]} : pos;
   wire [15:0] din = sd_dq_oe ? sd_dq_out : ~sd_dq_out;
   wire [3:0] bl = 4'h1 << cfg[1:0];
   always @(posedge ref_clk) begin
      cke_d <= sd_cke;
      p1 <= mem[a];
      p2 <= p1;
      v1 <= (rcmd || (step && !wr_on)) && open_b[a[11:10]];
      v2 <= v1;
      z1 <= |sd_dqm;
      sd_dq_in <= (cfg[2] ? v2 : v1) && !z1 ? (cfg[2] ? p2 : p1) : ~sd_dq_in;
      if ((wcmd || (step && wr_on)) && open_b[a[11:10]]) begin
         if (!sd_dqm[0])
            mem[a][7:0] <= din[7:0];
         if (!sd_dqm[1])
            mem[a][15:8] <= din[15:8];
      end
      if (wcmd || rcmd) begin
         wr_on <= wcmd;
         ap <= sd_addr[10];
         pos <= a + 12'h1;
         left <= bl - 4'h1;
      end else if (stop || pre)
         left <= 4'h0;
      else if (step) begin
         pos <= pos + 12'h1;
         left <= left - 4'h1;
      end
      if (((wcmd || rcmd) && bl == 4'h1 && sd_addr[10]) || (step && left == 4'h1 && ap))
         open_b[a[11:10]] <= 1'b0;
      if (run && cmd[2:0] == 3'b011)
         open_b[bank] <= 1'b1;
      if (refresh)
         open_b <= 4'h0;
      if (pre)
         open_b <= sd_addr[10] ? 4'h0 : open_b & ~(4'h1 << bank);
      if (run && !sd_cke && cmd[2:0] == 3'b110)
         for (int i = 0; i < 4096; i++)
            mem[i] <= ~mem[i];
   end
endmodule // sdram_partner

// [bench/sdram_command_engine_test.sv]
module sdram_command_engine_test;
   timeunit 1ns;
   timeprecision 1ps;
   logic ref_clk = 1'b0;
   logic resetn = 1'b0;
   logic [2:0] bus_addr = 3'h0;
   logic [31:0] bus_wdata = 32'h0;
   logic bus_wr = 1'b0;
   logic bus_rd = 1'b0;
   logic rd_seen = 1'b0;
   logic [2:0] cfg = 3'h3;
   logic [31:0] rnd = 32'h99012e71;
   logic [15:0] em [0:31];
   logic [63:0] notes [$];
   int n_errors = 0;
   int n_compared = 0;
   int cycles = 0;
   wire [31:0] bus_rdata;
   wire sd_cke, sd_cs_n, sd_ras_n, sd_cas_n, sd_we_n, bank_select_lo, bank_select_hi, sd_dq_oe;
   wire [12:0] sd_addr;
   wire [1:0] sd_dqm;
   wire [15:0] sd_dq_in, sd_dq_out;
   always #20 ref_clk = ~ref_clk;
   sdram_command_engine #(.PD_LIMIT(20)) u_sdram_command_engine (.ref_clk, .resetn, .bus_addr, .bus_wdata,
      .bus_wr, .bus_rd, .bus_rdata, .sd_cke, .sd_cs_n, .sd_ras_n, .sd_cas_n, .sd_we_n, .bank_select_lo,
      .bank_select_hi, .sd_addr, .sd_dqm, .sd_dq_in, .sd_dq_out, .sd_dq_oe);
   sdram_partner u_sdram_partner (.ref_clk, .sd_cke, .cmd({sd_cs_n, sd_ras_n, sd_cas_n, sd_we_n}),
      .bank({bank_select_hi, bank_select_lo}), .sd_addr, .sd_dqm, .sd_dq_out, .sd_dq_oe, .cfg, .sd_dq_in);
   // ***********
   // bus helpers
   // ***********
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return s[0] ? (s >> 1) ^ 32'h80200003 : s >> 1;
   endfunction
   function automatic logic [31:0] cw(input logic [3:0] op, input logic [1:0] b, input logic ap, input logic [4:0] a);
      return {11'h0, a, 9'h0, ap, b, op};
   endfunction
   task automatic finish_test;
      $display("errors %0d compared %0d", n_errors, n_compared);
      if (n_errors == 0 && n_compared > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask
   task automatic chk(input logic [31:0] g, input logic [31:0] e, input logic [31:0] m);
      n_compared++;
      if ((g & m) !== (e & m)) begin
         n_errors++;
         $display("unexpected at %0t: got %h expected %h", $time, g & m, e & m);
      end
   endtask
   // strobes stay up between calls so back-to-back cycles never assign twice in one step
   task automatic wr(input logic [2:0] a, input logic [31:0] d);
      bus_addr <= a;
      bus_wdata <= d;
      bus_wr <= 1'b1;
      bus_rd <= 1'b0;
      @(posedge ref_clk);
   endtask
   task automatic rd(input logic [2:0] a, input logic [31:0] e, input logic [31:0] m);
      notes.push_back({m, e});
      bus_addr <= a;
      bus_rd <= 1'b1;
      bus_wr <= 1'b0;
      @(posedge ref_clk);
   endtask
   task automatic nop;
      bus_rd <= 1'b0;
      bus_wr <= 1'b0;
      @(posedge ref_clk);
   endtask
   task automatic settle;
      logic b;
      b = 1'b1;
      for (int k = 0; k < 40 && b !== 1'b0; k++) begin
         rd(3'h3, 32'h0, 32'h0);
         bus_rd <= 1'b0;
         @(negedge ref_clk) b = bus_rdata[0];
         @(posedge ref_clk);
      end
      chk({31'h0, b}, 32'h0, 32'h1);
   endtask
   task automatic cmd(input logic [3:0] op, input logic [1:0] b, input logic ap, input logic [4:0] a);
      wr(3'h0, cw(op, b, ap, a));
      settle;
   endtask
   task automatic st(input logic [31:0] e, input logic [31:0] m);
      rd(3'h3, e, m);
      wr(3'h3, 32'h0);
   endtask
   task automatic setcfg(input logic [2:0] v);
      cfg <= v;
      wr(3'h2, {29'h0, v});
   endtask
   task automatic wburst(input logic [4:0] c, input int n, input logic [1:0] mk, input logic ap, input logic stp);
      logic [15:0] d;
      for (int i = 0; i < n; i++) begin
         d = rnd[15:0];
         rnd = lfsr(rnd);
         wr(3'h1, {14'h0, mk, d});
         if (!mk[0] && (!stp || i == 0))
            em[c + i][7:0] = d[7:0];
         if (!mk[1] && (!stp || i == 0))
            em[c + i][15:8] = d[15:8];
      end
      wr(3'h0, cw(4'h2, 2'h1, ap, c));
      if (stp)
         wr(3'h0, cw(4'h5, 2'h0, 1'b0, 5'h0));
      settle;
   endtask
   task automatic rchk(input logic [4:0] c, input logic cl3);
      setcfg({cl3, 2'h0});
      cmd(4'h3, 2'h1, 1'b0, c);
      repeat (4) nop;
      rd(3'h4, {16'h0, em[c]}, 32'hffff);
   endtask
   always @(posedge ref_clk) begin
      logic [63:0] n;
      cycles++;
      if (rd_seen && notes.size() > 0) begin
         n = notes.pop_front();
         if (n[63:32] != 32'h0)
            chk(bus_rdata, n[31:0], n[63:32]);
      end
      rd_seen <= bus_rd;
      if (cycles == 20000) begin
         n_errors++;
         finish_test;
      end
   end
   // *************
   // main sequence
   // *************
   initial begin
      repeat (16) @(posedge ref_clk);
      resetn <= 1'b1;
      rd(3'h2, 32'h3, 32'h7);
      rd(3'h7, 32'h0, 32'hffffffff);
      rd(3'h3, 32'h0, 32'h3ff);
      setcfg(3'h1);
      cmd(4'h1, 2'h1, 1'b0, 5'h5);
      st(32'h4, 32'h11e);
      cmd(4'h1, 2'h1, 1'b0, 5'h5);
      st(32'h104, 32'h11e);
      for (int m = 0; m < 4; m++)
         wburst(5'h8, 2, m[1:0], 1'b0, 1'b0);
      setcfg(3'h2);
      wburst(5'h10, 4, 2'h0, 1'b0, 1'b0);
      wburst(5'h10, 4, 2'h0, 1'b0, 1'b1);
      // clock held low for one cycle in mid burst, once by suspend, once by power down
      for (int s = 0; s < 2; s++) begin
         setcfg(3'h2);
         for (int i = 0; i < 4; i++) begin
            em[4 + i] = rnd[15:0];
            wr(3'h1, {16'h0, rnd[15:0]});
            rnd = lfsr(rnd);
         end
         wr(3'h0, cw(4'h2, 2'h1, 1'b0, 5'h4));
         wr(3'h0, cw(s == 0 ? 4'hd : 4'h9, 2'h0, 1'b0, 5'h0));
         wr(3'h0, cw(4'he, 2'h0, 1'b0, 5'h0));
         settle;
         for (int i = 0; i < 4; i++)
            rchk(5'(4 + i), i[0]);
      end
      for (int i = 0; i < 6; i++)
         rchk(i < 2 ? 5'(8 + i) : 5'(14 + i), i[0]);
      setcfg(3'h1);
      wburst(5'h18, 2, 2'h0, 1'b1, 1'b0);
      wr(3'h1, 32'h0);
      cmd(4'h2, 2'h1, 1'b0, 5'h0);
      st(32'h100, 32'h11e);
      for (int b = 0; b < 4; b++)
         cmd(4'h1, b[1:0], 1'b0, 5'h3);
      cmd(4'h4, 2'h3, 1'b0, 5'h0);
      st(32'h0e, 32'h1e);
      cmd(4'h6, 2'h0, 1'b0, 5'h0);
      st(32'h100, 32'h100);
      cmd(4'h4, 2'h2, 1'b1, 5'h0);
      cmd(4'h6, 2'h0, 1'b0, 5'h0);
      st(32'h0, 32'h11e);
      for (int i = 0; i < 3; i++) begin
         wr(3'h0, cw(4'h7 + 4'(2 * i), 2'h0, 1'b0, 5'h0));
         nop;
         st(32'(i + 4) << 5, 32'h1e0);
         wr(3'h0, cw(4'h8 + 4'(2 * i), 2'h0, 1'b0, 5'h0));
         settle;
      end
      cmd(4'h1, 2'h1, 1'b0, 5'h5);
      st(32'h300, 32'h31e);
      setcfg(3'h1);
      wr(3'h0, cw(4'h9, 2'h0, 1'b0, 5'h0));
      repeat (25) nop;
      st(32'h0, 32'h3e0);
      nop;
      finish_test;
   end
endmodule // sdram_command_engine_test
